// >>> hw/psram_bus_defs.svh
// named constants for the memory-side bus state logic
// assumes inclusion by bare name from the package and design file
`ifndef PSRAM_BUS_DEFS_SVH
`define PSRAM_BUS_DEFS_SVH

// =====================================================
// command-address framing
`define CA_EDGES       3'h6
`define CA_W           48
`define CA_RW_BIT      47
`define CA_SPACE_BIT   46

// =====================================================
// initial latency, in link clock edges
`define LAT_EDGES      5'h0c

// =====================================================
// clock stop timing
`define INITIAL_ACCESS_TIME_NS        35
`define STOP_EXTRA_NS  30
`define CLK_PERIOD_NS  10
`define STOP_CYCLES    (((`INITIAL_ACCESS_TIME_NS + `STOP_EXTRA_NS) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STOP_CNT_W     4

// =====================================================
// write data buffer
`define DATA_W         8
`define FIFO_DEPTH     32

`endif

// >>> hw/psram_bus_pkg.sv
// types shared by the memory-side bus state logic
// assumes the defs header is on the include path
`include "psram_bus_defs.svh"

package psram_bus_pkg;

    // =====================================================
    // interface states, one-hot
    typedef enum logic [5:0] {
        ST_STANDBY = 6'h01,
        ST_CA      = 6'h02,
        ST_RD_LAT  = 6'h04,
        ST_WR_LAT  = 6'h08,
        ST_RD_DATA = 6'h10,
        ST_WR_DATA = 6'h20
    } bus_state_t;

    // =====================================================
    // pin inputs as sampled
    typedef struct packed {
        logic                cs_n;
        logic                ck;
        logic                ck_n;
        logic                reset_n;
        logic                supply_ok;
        logic [`DATA_W-1:0]  dq;
        logic                strobe_mask_line;
    } pins_in_t;

    // one written byte with its mask
    typedef struct packed {
        logic [`DATA_W-1:0]  data;
        logic                mask;
    } wr_beat_t;

endpackage : psram_bus_pkg

// >>> hw/psram_bus_states.sv
// memory-side bus ownership logic and its write data buffer
// assumes link pins arrive asynchronously and are sampled by CLK_I
`timescale 1ns/100ps
`include "psram_bus_defs.svh"

// =====================================================
// synchronous fifo, registered pointers
module sync_fifo #(
    parameter int W     = 9,
    parameter int DEPTH = 32
) (
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // filling side
    input  wire logic          in_valid_i,
    output      logic          in_ready_o,
    input  wire logic [W-1:0]  in_data_i,
    // draining side
    output      logic          out_valid_o,
    input  wire logic          out_ready_i,
    output      logic [W-1:0]  out_data_o
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0]  mem [DEPTH];
    logic [AW:0]   wr_ptr;
    logic [AW:0]   rd_ptr;
    logic          push;
    logic          pop;

    // full when pointers differ only in the wrap bit
    assign in_ready_o  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign out_valid_o = (wr_ptr != rd_ptr);
    assign out_data_o  = mem[rd_ptr[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data_i;
        end
    end

    // pointers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : sync_fifo

// =====================================================
// bus state logic
module psram_bus_states (
    // clock and reset
    input  wire logic                      CLK_I,
    input  wire logic                      RST_I,
    // link pins
    input  wire logic                      CS_N_I,
    input  wire logic                      CK_I,
    input  wire logic                      CK_N_I,
    input  wire logic                      RESET_N_I,
    input  wire logic                      SUPPLY_OK_I,
    input  wire logic [`DATA_W-1:0]        DQ_I,
    output      logic [`DATA_W-1:0]        DQ_O,
    output      logic                      DQ_OE_N_O,
    input  wire logic                      STROBE_MASK_LINE_I,
    output      logic                      STROBE_MASK_LINE_O,
    output      logic                      STROBE_MASK_LINE_OE_N_O,
    // array side status
    input  wire logic                      REFRESH_PEND_I,
    output      logic [`CA_W-1:0]          CA_O,
    output      logic                      CA_VALID_O,
    output      logic                      CLK_STOP_O,
    // read data source
    input  wire logic [`DATA_W-1:0]        RD_DATA_I,
    input  wire logic                      RD_VALID_I,
    output      logic                      RD_TAKEN_O,
    // write data sink
    output      psram_bus_pkg::wr_beat_t   WR_BEAT_O,
    output      logic                      WR_VALID_O,
    input  wire logic                      WR_READY_I,
    output      logic                      WR_DROP_O
);
    psram_bus_pkg::pins_in_t    pin_s1;
    psram_bus_pkg::pins_in_t    pin_s2;
    psram_bus_pkg::bus_state_t  state;
    psram_bus_pkg::wr_beat_t    push_beat;
    logic                       ck_d;
    logic                       ck_edge;
    logic                       hold_off;
    logic                       ext_lat;
    logic                       zero_lat;
    logic [4:0]                 cnt;
    logic [4:0]                 lat_target;
    logic [`CA_W-1:0]           ca_sr;
    logic [`CA_W-1:0]           next_ca;
    logic [`STOP_CNT_W-1:0]     stop_cnt;
    logic                       push;
    logic                       push_ready;

    // two-stage pin synchroniser
    always_ff @(posedge CLK_I) begin
        pin_s1 <= {CS_N_I, CK_I, CK_N_I, RESET_N_I, SUPPLY_OK_I, DQ_I, STROBE_MASK_LINE_I};
        pin_s2 <= pin_s1;
    end

    // link clock edge detection on the settled sample
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ck_d <= 1'b0;
        end else begin
            ck_d <= pin_s2.ck;
        end
    end

    assign ck_edge    = pin_s2.ck ^ ck_d;
    assign hold_off   = RST_I || !pin_s2.reset_n || !pin_s2.supply_ok;
    assign next_ca    = {ca_sr[`CA_W-`DATA_W-1:0], pin_s2.dq};
    assign lat_target = ext_lat ? (`LAT_EDGES << 1) : `LAT_EDGES;

    // interface state and edge counter
    always_ff @(posedge CLK_I) begin
        if (hold_off || pin_s2.cs_n) begin
            state <= psram_bus_pkg::ST_STANDBY;
            cnt   <= '0;
        end else begin
            case (state)
                psram_bus_pkg::ST_STANDBY: begin
                    state <= psram_bus_pkg::ST_CA;
                    cnt   <= '0;
                end
                psram_bus_pkg::ST_CA: begin
                    if (ck_edge) begin
                        cnt <= cnt + 5'h01;
                        if (cnt == {2'b00, `CA_EDGES} - 5'h01) begin
                            cnt <= '0;
                            if (next_ca[`CA_RW_BIT]) begin
                                state <= psram_bus_pkg::ST_RD_LAT;
                            end else if (next_ca[`CA_SPACE_BIT]) begin
                                state <= psram_bus_pkg::ST_WR_DATA;
                            end else begin
                                state <= psram_bus_pkg::ST_WR_LAT;
                            end
                        end
                    end
                end
                psram_bus_pkg::ST_RD_LAT,
                psram_bus_pkg::ST_WR_LAT: begin
                    if (ck_edge) begin
                        cnt <= cnt + 5'h01;
                        if (cnt == lat_target - 5'h01) begin
                            cnt   <= '0;
                            state <= (state == psram_bus_pkg::ST_RD_LAT) ?
                                     psram_bus_pkg::ST_RD_DATA : psram_bus_pkg::ST_WR_DATA;
                        end
                    end
                end
                psram_bus_pkg::ST_RD_DATA,
                psram_bus_pkg::ST_WR_DATA: begin
                    state <= state;
                end
                default: begin
                    state <= psram_bus_pkg::ST_STANDBY;
                end
            endcase
        end
    end

    // refresh latency flag, caught at selection
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ext_lat <= 1'b0;
        end else if (state == psram_bus_pkg::ST_STANDBY) begin
            ext_lat <= REFRESH_PEND_I;
        end
    end

    // command-address shift register and zero-latency flag
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            ca_sr      <= '0;
            CA_O       <= '0;
            CA_VALID_O <= 1'b0;
            zero_lat   <= 1'b0;
        end else begin
            CA_VALID_O <= 1'b0;
            if (state == psram_bus_pkg::ST_STANDBY) begin
                zero_lat <= 1'b0;
            end
            if (!hold_off && !pin_s2.cs_n && state == psram_bus_pkg::ST_CA && ck_edge) begin
                ca_sr <= next_ca;
                if (cnt == {2'b00, `CA_EDGES} - 5'h01) begin
                    CA_O       <= next_ca;
                    CA_VALID_O <= 1'b1;
                    zero_lat   <= !next_ca[`CA_RW_BIT] && next_ca[`CA_SPACE_BIT];
                end
            end
        end
    end

    // pin drive per state; enables low while driving
    always_ff @(posedge CLK_I) begin
        if (hold_off || pin_s2.cs_n) begin
            DQ_OE_N_O   <= 1'b1;
            STROBE_MASK_LINE_OE_N_O <= 1'b1;
            DQ_O        <= '0;
            STROBE_MASK_LINE_O      <= 1'b0;
        end else begin
            case (state)
                psram_bus_pkg::ST_CA: begin
                    DQ_OE_N_O   <= 1'b1;
                    STROBE_MASK_LINE_OE_N_O <= 1'b0;
                    STROBE_MASK_LINE_O      <= ext_lat;
                end
                psram_bus_pkg::ST_RD_LAT: begin
                    DQ_OE_N_O   <= 1'b1;
                    STROBE_MASK_LINE_OE_N_O <= 1'b0;
                    STROBE_MASK_LINE_O      <= 1'b0;
                end
                psram_bus_pkg::ST_RD_DATA: begin
                    DQ_OE_N_O   <= 1'b0;
                    STROBE_MASK_LINE_OE_N_O <= 1'b0;
                    if (ck_edge) begin
                        if (RD_VALID_I) begin
                            DQ_O <= RD_DATA_I;
                        end
                        STROBE_MASK_LINE_O <= pin_s2.ck;
                    end
                end
                psram_bus_pkg::ST_WR_LAT,
                psram_bus_pkg::ST_WR_DATA: begin
                    DQ_OE_N_O   <= 1'b1;
                    STROBE_MASK_LINE_OE_N_O <= 1'b1;
                end
                default: begin
                    DQ_OE_N_O   <= 1'b1;
                    STROBE_MASK_LINE_OE_N_O <= 1'b1;
                end
            endcase
        end
    end

    // acknowledge of each read byte placed on the bus
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            RD_TAKEN_O <= 1'b0;
        end else begin
            RD_TAKEN_O <= !hold_off && !pin_s2.cs_n && ck_edge && RD_VALID_I &&
                          state == psram_bus_pkg::ST_RD_DATA;
        end
    end

    // clock stop detection; outputs simply hold their last value
    always_ff @(posedge CLK_I) begin
        if (RST_I || ck_edge || state == psram_bus_pkg::ST_STANDBY) begin
            stop_cnt   <= '0;
            CLK_STOP_O <= 1'b0;
        end else begin
            if (stop_cnt != `STOP_CNT_W'(`STOP_CYCLES)) begin
                stop_cnt <= stop_cnt + 1'b1;
            end
            CLK_STOP_O <= (stop_cnt == `STOP_CNT_W'(`STOP_CYCLES)) &&
                          !pin_s2.ck && pin_s2.ck_n;
        end
    end

    // write beats captured on each link edge
    assign push           = !hold_off && !pin_s2.cs_n && ck_edge && state == psram_bus_pkg::ST_WR_DATA;
    assign push_beat.data = pin_s2.dq;
    assign push_beat.mask = zero_lat ? 1'b0 : pin_s2.strobe_mask_line;

    // beat lost when the buffer is full, sticky until reset
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            WR_DROP_O <= 1'b0;
        end else if (push && !push_ready) begin
            WR_DROP_O <= 1'b1;
        end
    end

    // write data buffer
    sync_fifo #(
        .W     ($bits(psram_bus_pkg::wr_beat_t)),
        .DEPTH (`FIFO_DEPTH)
    ) wr_fifo (
        .clk_i       (CLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (push),
        .in_ready_o  (push_ready),
        .in_data_i   (push_beat),
        .out_valid_o (WR_VALID_O),
        .out_ready_i (WR_READY_I),
        .out_data_o  (WR_BEAT_O)
    );
endmodule : psram_bus_states

// >>> test/psram_bus_states_sva.sv
// assertions on the bus state block, ports only
// assumes a bind from the bench top file
`timescale 1ns/100ps
`include "psram_bus_defs.svh"

// ==========================================
// checker
module psram_bus_states_sva (
    // clock and reset
    input wire logic               CLK_I,
    input wire logic               RST_I,
    // link pins
    input wire logic               CS_N_I,
    input wire logic               CK_I,
    input wire logic               CK_N_I,
    input wire logic               RESET_N_I,
    input wire logic               SUPPLY_OK_I,
    input wire logic [`DATA_W-1:0] DQ_O,
    input wire logic               DQ_OE_N_O,
    input wire logic               STROBE_MASK_LINE_O,
    input wire logic               STROBE_MASK_LINE_OE_N_O,
    // array side
    input wire logic               REFRESH_PEND_I,
    input wire logic [`CA_W-1:0]   CA_O,
    input wire logic               CA_VALID_O,
    input wire logic               CLK_STOP_O,
    input wire logic [`DATA_W-1:0] RD_DATA_I,
    input wire logic               RD_TAKEN_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    logic [3:0] idle_cnt;

    // run of idle clock samples while selected
    always_ff @(posedge CLK_I) begin
        if (RST_I || CS_N_I || CK_I || !CK_N_I) idle_cnt <= 4'h0;
        else if (idle_cnt != 4'hf) idle_cnt <= idle_cnt + 4'h1;
    end

    // kinds of captured command word
    sequence s_rd_ca; CA_VALID_O && CA_O[`CA_RW_BIT]; endsequence
    sequence s_wr_ca; CA_VALID_O && !CA_O[`CA_RW_BIT] && !CA_O[`CA_SPACE_BIT]; endsequence
    sequence s_zl_ca; CA_VALID_O && !CA_O[`CA_RW_BIT] && CA_O[`CA_SPACE_BIT]; endsequence

    a_reset_idle: assert property ($past(RST_I) |-> DQ_OE_N_O && STROBE_MASK_LINE_OE_N_O)
        else $error("bus driven right after reset");
    a_hw_reset: assert property (!RESET_N_I [*5] |-> DQ_OE_N_O && STROBE_MASK_LINE_OE_N_O)
        else $error("bus driven in hardware reset");
    a_low_supply: assert property (!SUPPLY_OK_I [*5] |-> DQ_OE_N_O && STROBE_MASK_LINE_OE_N_O)
        else $error("bus driven with low supply");
    a_standby_idle: assert property (CS_N_I [*6] |-> DQ_OE_N_O && STROBE_MASK_LINE_OE_N_O)
        else $error("bus driven in standby");
    a_flag_drive: assert property ($fell(CS_N_I) && RESET_N_I && SUPPLY_OK_I |-> ##[2:8] !STROBE_MASK_LINE_OE_N_O)
        else $error("strobe not driven in address phase");
    a_flag_value: assert property ($fell(STROBE_MASK_LINE_OE_N_O) |-> STROBE_MASK_LINE_O == $past(REFRESH_PEND_I, 4))
        else $error("latency flag wrong");
    a_read_lat: assert property (s_rd_ca |-> ##3 (DQ_OE_N_O && !STROBE_MASK_LINE_OE_N_O && !STROBE_MASK_LINE_O) [*8])
        else $error("read latency bus state wrong");
    a_write_lat: assert property (s_wr_ca |-> ##3 (DQ_OE_N_O && STROBE_MASK_LINE_OE_N_O) [*8])
        else $error("write latency bus not released");
    a_zero_lat: assert property (s_zl_ca |-> ##3 (DQ_OE_N_O && STROBE_MASK_LINE_OE_N_O) [*4])
        else $error("zero latency write strobe driven");
    a_read_beat: assert property (RD_TAKEN_O |-> !DQ_OE_N_O && DQ_O == $past(RD_DATA_I, 1))
        else $error("read byte not on data lines");
    a_stop_enter: assert property ($rose(CLK_STOP_O) |-> $past(idle_cnt, 3) >= 4'h6)
        else $error("clock stop flagged early");
    a_stop_reach: assert property (idle_cnt == 4'hf |-> CLK_STOP_O && $stable(DQ_O))
        else $error("clock stop missed or data moved");
endmodule : psram_bus_states_sva

// >>> test/psram_host_model.sv
// host controller model on the link pins
// assumes the bench resolves wire levels from all enables
`timescale 1ns/100ps
`include "psram_bus_defs.svh"

// ==========================================
// host model
module psram_host_model (
    // pins toward the device
    output logic               cs_n_o,
    output logic               ck_o,
    output logic               ck_n_o,
    output logic [`DATA_W-1:0] dq_o,
    output logic               dq_oe_n_o,
    output logic               strobe_mask_line_o,
    output logic               strobe_mask_line_oe_n_o,
    // resolved wire levels
    input  wire logic [`DATA_W-1:0] dq_i,
    input  wire logic               strobe_mask_line_i
);
    localparam realtime Q = 31.25; // quarter link period

    // idle pins, clock parked low
    initial begin
        cs_n_o = 1'b1;
        ck_o = 1'b0;
        ck_n_o = 1'b1;
        dq_o = 8'h00;
        dq_oe_n_o = 1'b1;
        strobe_mask_line_o = 1'b0;
        strobe_mask_line_oe_n_o = 1'b1;
    end

    // one link edge, sampling just before it
    task automatic step(output logic [`DATA_W-1:0] d, output logic s, output logic c);
        #Q;
        d = dq_i;
        s = strobe_mask_line_i;
        c = ck_o;
        ck_o = ~ck_o;
        ck_n_o = ~ck_n_o;
        #Q;
    endtask : step

    // whole frame: address, latency, data
    task automatic xfer(input logic [`CA_W-1:0] ca, input int n, input logic [`DATA_W-1:0] dat,
                        input logic msk, input int stop_ns, output logic ext, output int bad);
        logic [`DATA_W-1:0] d;
        logic s;
        logic c;
        int lat;
        bad = 0;
        ext = 1'b0;
        cs_n_o = 1'b0;
        dq_oe_n_o = 1'b0;
        for (int i = 0; i < 6; i++) begin
            dq_o = ca[`CA_W-1-8*i -: 8];
            step(d, s, c);
            if (i == 5) ext = s;
        end
        dq_oe_n_o = 1'b1;
        lat = (ca[`CA_RW_BIT] || !ca[`CA_SPACE_BIT]) ? (ext ? 24 : 12) : 0;
        for (int i = 0; i < lat; i++) begin
            step(d, s, c);
            if (ca[`CA_RW_BIT] && i > 1 && s !== 1'b0) bad++;
        end
        for (int k = 0; k < n; k++) begin
            if (!ca[`CA_RW_BIT]) begin
                dq_o = dat + 8'(k);
                dq_oe_n_o = 1'b0;
                strobe_mask_line_o = msk;
                strobe_mask_line_oe_n_o = (lat == 0);
            end
            if (k == 2 && stop_ns > 0) #(stop_ns);
            step(d, s, c);
            if (ca[`CA_RW_BIT] && k > 1 && (d !== dat || s !== c)) bad++;
        end
        dq_oe_n_o = 1'b1;
        strobe_mask_line_oe_n_o = 1'b1;
        #(2*Q);
        cs_n_o = 1'b1;
        #(4*Q);
    endtask : xfer
endmodule : psram_host_model

// >>> test/tb_psram_bus_states.sv
// self-checking bench for the bus state block
// assumes the host model and checker files compile first
`timescale 1ns/100ps
`include "psram_bus_defs.svh"

// ==========================================
// bench top
module tb_psram_bus_states;
    typedef struct {logic [47:0] ca; int n; logic [7:0] dat; logic msk; logic refr; int stop;} row_t;
    row_t rows [5] = '{
        '{48'h8000_0000_0100, 4, 8'h5a, 1'b0, 1'b0, 300}, // read, paused clock
        '{48'h8000_0000_0200, 4, 8'ha5, 1'b0, 1'b1, 0},
        '{48'h0000_0000_0300, 4, 8'h30, 1'b0, 1'b0, 0},
        '{48'h0000_0000_0400, 4, 8'h40, 1'b1, 1'b1, 0},
        '{48'h4000_0000_0500, 4, 8'h50, 1'b1, 1'b0, 0}  // zero latency write
    };
    logic clk, rst, refresh, rd_valid, wr_ready, reset_n, supply_ok, cs_n, ck, ck_n;
    logic h_dq_oe_n, h_strobe_mask_line, h_strobe_mask_line_oe_n, strobe_mask_line_wire, dq_oe_n, strobe_mask_line_o, strobe_mask_line_oe_n;
    logic ca_valid, clk_stop, rd_taken, wr_valid, wr_drop, stop_seen, drove;
    logic [7:0] rd_data, h_dq, dq_wire, dq_o;
    logic [7:0] float_pat = 8'h0f;
    logic [47:0] ca, ca_seen;
    psram_bus_pkg::wr_beat_t beat;
    psram_bus_pkg::wr_beat_t beats [$];
    int n_mismatch = 0;
    int n_tests = 0;
    int cycles = 0;

    // wire levels; a released line keeps changing
    assign dq_wire = !dq_oe_n ? dq_o : !h_dq_oe_n ? h_dq : float_pat;
    assign strobe_mask_line_wire = !strobe_mask_line_oe_n ? strobe_mask_line_o : !h_strobe_mask_line_oe_n ? h_strobe_mask_line : float_pat[0];

    psram_host_model host (.cs_n_o(cs_n), .ck_o(ck), .ck_n_o(ck_n), .dq_o(h_dq), .dq_oe_n_o(h_dq_oe_n),
        .strobe_mask_line_o(h_strobe_mask_line), .strobe_mask_line_oe_n_o(h_strobe_mask_line_oe_n), .dq_i(dq_wire), .strobe_mask_line_i(strobe_mask_line_wire));
    psram_bus_states psram_bus_states_inst (.CLK_I(clk), .RST_I(rst), .CS_N_I(cs_n), .CK_I(ck), .CK_N_I(ck_n),
        .RESET_N_I(reset_n), .SUPPLY_OK_I(supply_ok), .DQ_I(dq_wire), .DQ_O(dq_o), .DQ_OE_N_O(dq_oe_n),
        .STROBE_MASK_LINE_I(strobe_mask_line_wire), .STROBE_MASK_LINE_O(strobe_mask_line_o), .STROBE_MASK_LINE_OE_N_O(strobe_mask_line_oe_n), .REFRESH_PEND_I(refresh), .CA_O(ca),
        .CA_VALID_O(ca_valid), .CLK_STOP_O(clk_stop), .RD_DATA_I(rd_data), .RD_VALID_I(rd_valid),
        .RD_TAKEN_O(rd_taken), .WR_BEAT_O(beat), .WR_VALID_O(wr_valid), .WR_READY_I(wr_ready),
        .WR_DROP_O(wr_drop));

    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // compare and count
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : check

    // counts and verdict
    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude

    // captured words, popped beats, activity, timeout
    always @(posedge clk) begin
        float_pat <= ~float_pat;
        if (ca_valid) ca_seen <= ca;
        if (wr_valid && wr_ready) beats.push_back(beat);
        if (clk_stop) stop_seen <= 1'b1;
        if (!dq_oe_n || !strobe_mask_line_oe_n) drove <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    // main sequence
    initial begin
        logic ext;
        int bad;
        rst <= 1'b1;
        refresh <= 1'b0;
        rd_data <= 8'h00;
        rd_valid <= 1'b1;
        wr_ready <= 1'b1;
        reset_n <= 1'b1;
        supply_ok <= 1'b1;
        repeat (3) @(posedge clk);
        check(dq_oe_n & strobe_mask_line_oe_n, 1);
        rst <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            @(posedge clk);
            refresh <= rows[i].refr;
            rd_data <= rows[i].dat;
            stop_seen <= 1'b0;
            beats.delete();
            repeat (8) @(posedge clk);
            host.xfer(rows[i].ca, rows[i].n, rows[i].dat, rows[i].msk, rows[i].stop, ext, bad);
            repeat (8) @(posedge clk);
            check(ca_seen, rows[i].ca);
            check(ext, rows[i].refr);
            check(bad, 0);
            if (rows[i].stop > 0) check(stop_seen, 1);
            if (!rows[i].ca[47]) check(beats.size(), rows[i].n);
            if (!rows[i].ca[47]) foreach (beats[k]) check(beats[k], {rows[i].dat + 8'(k), rows[i].msk & !rows[i].ca[46]});
            $display("row %0d done", i);
        end
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            reset_n <= (j != 0);
            supply_ok <= (j == 0);
            repeat (8) @(posedge clk);
            drove <= 1'b0;
            host.xfer(rows[0].ca, 4, 8'h5a, 1'b0, 0, ext, bad);
            check(drove, 0);
            reset_n <= 1'b1;
            supply_ok <= 1'b1;
            repeat (8) @(posedge clk);
            $display("off-bus case %0d done", j);
        end
        wr_ready <= 1'b0;
        beats.delete();
        check(wr_drop, 0);
        host.xfer(48'h4000_0000_0600, 34, 8'h60, 1'b1, 0, ext, bad);
        check(wr_drop, 1);
        check(wr_valid, 1);
        @(posedge clk);
        wr_ready <= 1'b1;
        repeat (40) @(posedge clk);
        check(beats.size(), 32);
        check(beats[31], {8'h7f, 1'b0});
        check(wr_valid, 0);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check(wr_drop, 0);
        $display("buffer case done");
        conclude();
    end
endmodule : tb_psram_bus_states

bind psram_bus_states psram_bus_states_sva psram_bus_states_sva_inst (.*);
